// ==== sp_serial_port.sv ====
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
module sp_serial_port (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire sp_pkg::sp_wb_req_s wb_req_in,
  output sp_pkg::sp_wb_rsp_s wb_rsp_out,
  input wire logic rx_line_in,
  output logic tx_line_out,
  output logic tx_line_oe_out,
  output logic sync_clk_out,
  output logic sync_clk_oe_out,
  output logic irq_out
);
  import sp_pkg::*;

  // ==========================================================
  // Register bus
  logic ack_reg;
  logic [7:0] rdat_reg;
  logic [7:0] ctrl1_reg;
  logic [7:0] ctrl2_reg;
  logic [7:0] stat_reg;
  logic [7:0] mask_reg;
  logic [7:0] baud_reg;
  logic [7:0] txd_reg;
  logic [7:0] rxd_reg;
  logic rxb8_reg;

  wire req = wb_req_in.cyc & wb_req_in.stb;
  wire [5:0] idx = wb_req_in.adr[7:2];
  wire wr_cyc = req & ack_reg & wb_req_in.we & wb_req_in.sel[0];
  wire wr_baud = wr_cyc & (idx == IDX_BAUD);
  wire wr_c1 = wr_cyc & (idx == IDX_CTRL1);
  wire wr_c2 = wr_cyc & (idx == IDX_CTRL2);
  wire wr_stat = wr_cyc & (idx == IDX_STAT);
  wire wr_data = wr_cyc & (idx == IDX_DATA);
  wire wr_mask = wr_cyc & (idx == IDX_MASK);
  wire [7:0] wdat = wb_req_in.dat[7:0];
  wire [7:0] c1_view = {rxb8_reg, ctrl1_reg[6], 1'b0, ctrl1_reg[4:0]};
  wire [7:0] rd_mux =
    (idx == IDX_BAUD) ? baud_reg :
    (idx == IDX_CTRL1) ? c1_view :
    (idx == IDX_CTRL2) ? ctrl2_reg :
    (idx == IDX_STAT) ? stat_reg :
    (idx == IDX_DATA) ? rxd_reg :
    (idx == IDX_MASK) ? mask_reg : 8'h00;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_reg <= 1'b0;
      rdat_reg <= 8'h00;
    end else begin
      ack_reg <= req & ~ack_reg;
      rdat_reg <= rd_mux;
    end
  end
  assign wb_rsp_out.ack = ack_reg;
  assign wb_rsp_out.dat = {24'h000000, rdat_reg};

  // ==========================================================
  // Control fields
  wire char9 = ctrl1_reg[C1_LEN];
  wire rouse = ctrl1_reg[C1_ROUSE];
  wire idle_lvl = ctrl1_reg[C1_IDLE_LVL];
  wire phase = ctrl1_reg[C1_PHASE];
  wire last_bit_clock_en = ctrl1_reg[C1_LAST_BIT_CLOCK_EN];
  wire tx_on = ctrl2_reg[C2_TE];
  wire rx_on = ctrl2_reg[C2_RE];
  wire sleep = ctrl2_reg[C2_SLEEP];
  wire brk = ctrl2_reg[C2_BRK];
  wire [3:0] frame_len = char9 ? FRAME9_BITS : FRAME8_BITS;
  wire [3:0] data_bits = frame_len - 4'd2;

  // ==========================================================
  // Sixteen-times bit rate enable
  logic [7:0] div_reg;
  wire tick = (div_reg == baud_reg);
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= tick ? 8'h00 : div_reg + 8'h01;
    end
  end

  // ==========================================================
  // Transmitter
  sp_tx_state_e tx_st_reg;
  logic [3:0] tx_sub_reg;
  logic [3:0] tx_cnt_reg;
  logic [10:0] tx_sh_reg;
  logic tx_on_d_reg;
  logic pre_pend_reg;
  logic sclk_reg;
  logic brk_pend_reg;
  wire brk_req = brk | brk_pend_reg;
  wire bit_end = tick & (tx_sub_reg == SUB_LAST);
  wire tx_last = (tx_cnt_reg == frame_len - 4'd1);
  wire tx_rise = tx_on & ~tx_on_d_reg;
  wire tx_work = pre_pend_reg | brk_req | ~stat_reg[ST_TX_BUF_EMPTY_FLAG];
  wire tx_load = (tx_st_reg == TX_IDLE) & bit_end & tx_on & ~pre_pend_reg & ~brk_req
    & ~stat_reg[ST_TX_BUF_EMPTY_FLAG];
  wire tx_quiet = (tx_st_reg == TX_IDLE) & bit_end & tx_on & ~tx_work;
  wire [10:0] tx_frame = char9 ? {1'b1, ctrl1_reg[C1_TXB8], txd_reg, 1'b0}
    : {2'b11, txd_reg, 1'b0};
  wire in_data = (tx_st_reg == TX_FRAME) & (tx_cnt_reg != 4'd0)
    & (tx_cnt_reg <= data_bits);
  wire clk_bit = in_data & ((tx_cnt_reg != data_bits) | last_bit_clock_en);
  wire clk_half = phase ? (tx_sub_reg < SUB_HALF) : (tx_sub_reg >= SUB_HALF);

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_on_d_reg <= 1'b0;
      tx_sub_reg <= 4'h0;
    end else begin
      tx_on_d_reg <= tx_on;
      if (tick) begin
        tx_sub_reg <= tx_sub_reg + 4'h1;
      end
    end
  end

  // short break pulse kept until the block starts
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      brk_pend_reg <= 1'b0;
    end else if (!tx_on) begin
      brk_pend_reg <= 1'b0;
    end else if (brk) begin
      brk_pend_reg <= 1'b1;
    end else if (tx_st_reg == TX_BRK) begin
      brk_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pre_pend_reg <= 1'b0;
    end else if (tx_rise) begin
      pre_pend_reg <= 1'b1;
    end else if (tx_st_reg == TX_PRE && bit_end && tx_last) begin
      pre_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_st_reg <= TX_OFF;
      tx_cnt_reg <= 4'h0;
      tx_sh_reg <= 11'h7ff;
    end else begin
      case (tx_st_reg)
        TX_OFF: begin
          if (tx_on) begin
            tx_st_reg <= TX_IDLE;
          end
        end
        TX_IDLE: begin
          tx_cnt_reg <= 4'h0;
          if (!tx_on) begin
            tx_st_reg <= TX_OFF;
          end else if (bit_end && pre_pend_reg) begin
            tx_st_reg <= TX_PRE;
          end else if (bit_end && brk_req) begin
            tx_st_reg <= TX_BRK;
          end else if (tx_load) begin
            tx_st_reg <= TX_FRAME;
            tx_sh_reg <= tx_frame;
          end
        end
        TX_FRAME: begin
          if (bit_end) begin
            tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
            tx_cnt_reg <= tx_cnt_reg + 4'h1;
            if (tx_last) begin
              tx_st_reg <= tx_on ? TX_IDLE : TX_OFF;
            end
          end
        end
        TX_PRE: begin
          if (bit_end) begin
            tx_cnt_reg <= tx_cnt_reg + 4'h1;
            if (tx_last) begin
              tx_st_reg <= tx_on ? TX_IDLE : TX_OFF;
            end
          end
        end
        TX_BRK: begin
          if (bit_end) begin
            tx_cnt_reg <= tx_last ? 4'h0 : tx_cnt_reg + 4'h1;
            if (tx_last && !brk) begin
              tx_st_reg <= TX_MARK;
            end
          end
        end
        TX_MARK: begin
          if (bit_end) begin
            tx_st_reg <= tx_on ? TX_IDLE : TX_OFF;
          end
        end
        default: begin
          tx_st_reg <= TX_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sclk_reg <= 1'b0;
    end else begin
      sclk_reg <= (clk_bit & clk_half) ? ~idle_lvl : idle_lvl;
    end
  end

  assign tx_line_oe_out = (tx_st_reg != TX_OFF);
  assign sync_clk_oe_out = (tx_st_reg != TX_OFF);
  assign tx_line_out = (tx_st_reg == TX_FRAME) ? tx_sh_reg[0] : (tx_st_reg != TX_BRK);
  assign sync_clk_out = sclk_reg;

  // ==========================================================
  // Receive line synchroniser
  logic rx_m1_reg;
  logic rx_m2_reg;
  logic rx_m3_reg;
  logic rx_lvl_reg;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_m1_reg <= 1'b1;
      rx_m2_reg <= 1'b1;
      rx_m3_reg <= 1'b1;
      rx_lvl_reg <= 1'b1;
    end else begin
      rx_m1_reg <= rx_line_in;
      rx_m2_reg <= rx_m1_reg;
      rx_m3_reg <= rx_m2_reg;
      if (rx_m2_reg == rx_m3_reg) begin
        rx_lvl_reg <= rx_m2_reg;
      end
    end
  end

  // ==========================================================
  // Receiver
  sp_rx_state_e rx_st_reg;
  logic [3:0] rx_sub_reg;
  logic [3:0] rx_cnt_reg;
  logic [8:0] rx_sh_reg;
  logic [1:0] smp_reg;
  logic nz_reg;
  logic [3:0] ones_reg;
  logic idle_arm_reg;
  wire vote_pt = tick & (rx_sub_reg == SUB_VOTE);
  wire vote = (smp_reg[0] & smp_reg[1]) | (smp_reg[0] & rx_lvl_reg)
    | (smp_reg[1] & rx_lvl_reg);
  wire noisy = ~((smp_reg[0] == smp_reg[1]) & (smp_reg[1] == rx_lvl_reg));
  wire [3:0] ones_thr = frame_len;
  wire line_idle = (ones_reg >= ones_thr);
  wire ones_hit = vote_pt & vote & (ones_reg == ones_thr - 4'd1);
  wire frame_end = vote_pt & (rx_st_reg == RX_STOP);
  wire [7:0] rx_byte = char9 ? rx_sh_reg[7:0] : rx_sh_reg[8:1];
  // address mark is the last data bit
  wire addr_mark = rx_sh_reg[8];
  wire wake_addr = frame_end & sleep & rouse & addr_mark;
  // receive flags need enabled, awake receiver
  wire rx_ok = rx_on & (~sleep | wake_addr);
  wire rx_take = frame_end & rx_ok & ~stat_reg[ST_FULL] & ~stat_reg[ST_FERR];
  wire rx_ovr = frame_end & rx_ok & stat_reg[ST_FULL];
  wire idle_evt = ones_hit & rx_on & ~sleep & idle_arm_reg;
  wire wake_idle = ones_hit & sleep & ~rouse;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_st_reg <= RX_IDLE;
      rx_sub_reg <= 4'h0;
      rx_cnt_reg <= 4'h0;
      rx_sh_reg <= 9'h000;
      smp_reg <= 2'b11;
      nz_reg <= 1'b0;
      ones_reg <= 4'h0;
    end else if (tick) begin
      rx_sub_reg <= rx_sub_reg + 4'h1;
      smp_reg <= {smp_reg[0], rx_lvl_reg};
      if (vote_pt && rx_st_reg != RX_START) begin
        ones_reg <= !vote ? 4'h0 : (line_idle ? ones_reg : ones_reg + 4'h1);
      end
      case (rx_st_reg)
        RX_IDLE: begin
          if (!rx_lvl_reg && rx_sub_reg != SUB_HALF) begin
            rx_st_reg <= RX_START;
            rx_sub_reg <= 4'h1;
          end
        end
        RX_START: begin
          if (vote_pt) begin
            rx_st_reg <= vote ? RX_IDLE : RX_DATA;
            rx_cnt_reg <= 4'h0;
            nz_reg <= noisy;
            if (!vote) begin
              ones_reg <= 4'h0;
            end
          end
        end
        RX_DATA: begin
          if (vote_pt) begin
            rx_sh_reg <= {vote, rx_sh_reg[8:1]};
            nz_reg <= nz_reg | noisy;
            rx_cnt_reg <= rx_cnt_reg + 4'h1;
            if (rx_cnt_reg == data_bits - 4'd1) begin
              rx_st_reg <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (vote_pt) begin
            nz_reg <= nz_reg | noisy;
            rx_st_reg <= RX_IDLE;
          end
        end
        default: begin
          rx_st_reg <= RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rxd_reg <= 8'h00;
      rxb8_reg <= 1'b0;
      idle_arm_reg <= 1'b0;
    end else begin
      if (rx_take) begin
        rxd_reg <= rx_byte;
        rxb8_reg <= rx_sh_reg[8];
      end
      if (rx_take) begin
        idle_arm_reg <= 1'b1;
      end else if (idle_evt) begin
        idle_arm_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Control and data registers
  wire sleep_req = wdat[C2_SLEEP] & ~(~rouse & line_idle);
  wire [7:0] c2_wr = {wdat[7:2], sleep_req, wdat[C2_BRK]};
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl1_reg <= C1_RESET;
      ctrl2_reg <= C2_RESET;
      mask_reg <= MASK_RESET;
      baud_reg <= BAUD_RESET;
      txd_reg <= 8'h00;
    end else begin
      if (wr_c1) begin
        ctrl1_reg <= wdat & C1_WR_MASK;
      end
      if (wr_mask) begin
        mask_reg <= wdat;
      end
      if (wr_baud) begin
        baud_reg <= wdat;
      end
      if (wr_data) begin
        txd_reg <= wdat;
      end
      // sleep refused while idle in idle-wake mode; hardware wake clears it
      if (wr_c2) begin
        ctrl2_reg <= c2_wr;
      end else if (wake_idle || wake_addr) begin
        ctrl2_reg[C2_SLEEP] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Status and interrupt
  logic [7:0] st_set;
  logic [7:0] st_clr;
  always_comb begin
    st_set = 8'h00;
    st_clr = wr_stat ? wdat : 8'h00;
    if (wr_data) begin
      st_clr[ST_TX_BUF_EMPTY_FLAG] = 1'b1;
      st_clr[ST_TC] = 1'b1;
    end
    st_set[ST_TX_BUF_EMPTY_FLAG] = tx_load;
    st_set[ST_TC] = tx_quiet;
    // address character fills the receive register
    st_set[ST_FULL] = rx_take;
    st_set[ST_NOISE] = rx_take & nz_reg;
    st_set[ST_FERR] = rx_take & ~vote;
    st_set[ST_OVR] = rx_ovr;
    st_set[ST_IDLE] = idle_evt;
    st_clr[0] = 1'b1;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stat_reg <= ST_RESET;
    end else begin
      stat_reg <= (stat_reg & ~st_clr) | st_set;
    end
  end

  wire [7:0] src_gate = {ctrl2_reg[C2_TIE], ctrl2_reg[C2_TX_DONE_IRQ_EN], ctrl2_reg[C2_RIE],
    ctrl2_reg[C2_QIE], ctrl2_reg[C2_RIE], 3'b000};
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(stat_reg & mask_reg & src_gate);
    end
  end

endmodule : sp_serial_port

// ==== sp_pkg.sv ====
// Function
// - Nine-bit mode: received ninth bit lands in rx_bit8 with the low byte.
// - Nine-bit mode: tx_bit8 copied into shifter ninth position on each load.
// - char_len_sel picks nine or eight data bits for both directions.
// - Idle wake: sleep ends after 10/11 ones; sleep refused while line idle.
// - Address wake: one in last data bit wakes, stores character, sets full.
// - Outside frames sync clock rests at sclk_idle_level.
// - sclk_phase picks clock pulse at start or middle of each data bit.
// - Last data bit clock emitted only when last_bit_clock_en is one.
// - Interrupt sources gated by their enable bits.
// - Transmitter enable rising drives pins and sends 10/11 ones preamble.
// - Disabling transmitter finishes current byte before pins float.
// - Re-enable during a byte: finish it, then send a new preamble.
// - Receiver disabled: no receive status flags get set.
// - Receiver asleep: no flags set; existing flags kept.
// - Break pulse sends 10/11 zeros; held break repeats whole blocks.
// - After a break at least one high bit precedes any start bit.
package sp_pkg;
  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [5:0] IDX_BAUD = 6'h0d;
  localparam logic [5:0] IDX_CTRL1 = 6'h0e;
  localparam logic [5:0] IDX_CTRL2 = 6'h0f;
  localparam logic [5:0] IDX_STAT = 6'h10;
  localparam logic [5:0] IDX_DATA = 6'h11;
  localparam logic [5:0] IDX_MASK = 6'h12;
  // ==========================================================
  // Control 1 fields
  localparam int C1_RXB8 = 7;
  localparam int C1_TXB8 = 6;
  localparam int C1_LEN = 4;
  localparam int C1_ROUSE = 3;
  localparam int C1_IDLE_LVL = 2;
  localparam int C1_PHASE = 1;
  localparam int C1_LAST_BIT_CLOCK_EN = 0;
  localparam logic [7:0] C1_WR_MASK = 8'h5f;
  localparam logic [7:0] C1_RESET = 8'h00;
  // ==========================================================
  // Control 2 fields
  localparam int C2_TIE = 7;
  localparam int C2_TX_DONE_IRQ_EN = 6;
  localparam int C2_RIE = 5;
  localparam int C2_QIE = 4;
  localparam int C2_TE = 3;
  localparam int C2_RE = 2;
  localparam int C2_SLEEP = 1;
  localparam int C2_BRK = 0;
  localparam logic [7:0] C2_RESET = 8'h00;
  // ==========================================================
  // Status fields
  localparam int ST_TX_BUF_EMPTY_FLAG = 7;
  localparam int ST_TC = 6;
  localparam int ST_FULL = 5;
  localparam int ST_IDLE = 4;
  localparam int ST_OVR = 3;
  localparam int ST_NOISE = 2;
  localparam int ST_FERR = 1;
  localparam logic [7:0] ST_RESET = 8'hc0;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] BAUD_RESET = 8'h00;
  // ==========================================================
  // Frame timing
  localparam logic [3:0] FRAME8_BITS = 4'd10;
  localparam logic [3:0] FRAME9_BITS = 4'd11;
  localparam logic [3:0] SUB_LAST = 4'd15;
  localparam logic [3:0] SUB_HALF = 4'd8;
  localparam logic [3:0] SUB_VOTE = 4'd9;
  // ==========================================================
  // Bus carriers and state encodings
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } sp_wb_req_s;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } sp_wb_rsp_s;
  typedef enum logic [2:0] {
    TX_OFF = 3'b000, TX_IDLE = 3'b001, TX_PRE = 3'b011,
    TX_FRAME = 3'b010, TX_BRK = 3'b110, TX_MARK = 3'b111
  } sp_tx_state_e;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b11, RX_STOP = 2'b10
  } sp_rx_state_e;
endpackage : sp_pkg

// ==== sp_serial_port_chk.sv ====
`timescale 1ns/1ps
module sp_serial_port_chk (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire sp_pkg::sp_wb_req_s wb_req_in,
  input wire sp_pkg::sp_wb_rsp_s wb_rsp_out,
  input wire logic rx_line_in,
  input wire logic tx_line_out,
  input wire logic tx_line_oe_out,
  input wire logic sync_clk_out,
  input wire logic sync_clk_oe_out,
  input wire logic irq_out
);
  import sp_pkg::*;
  // ==========================================================
  // Shadow state, counts in clocks with the baud register at zero
  localparam int PRE_MIN = 160;
  localparam int REST_MIN = 177;
  logic idle_lvl_reg;
  logic [3:0] irq_en_reg;
  logic [8:0] hi_run_reg;
  logic [8:0] lo_run_reg;
  logic fresh_reg;
  wire req_live = wb_req_in.cyc && wb_req_in.stb && !wb_rsp_out.ack;
  wire wr_hit = wb_req_in.we && wb_req_in.sel[0] && wb_rsp_out.ack;
  wire [5:0] wr_idx = wb_req_in.adr[7:2];
  wire sclk_act = tx_line_oe_out && (sync_clk_out != idle_lvl_reg);
  wire tx_hi = tx_line_oe_out && tx_line_out;
  wire tx_lo = tx_line_oe_out && !tx_line_out;
  wire [8:0] hi_inc = {8'h0, hi_run_reg != 9'h1ff};
  wire [8:0] lo_inc = {8'h0, lo_run_reg != 9'h1ff};
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      idle_lvl_reg <= 1'b0;
      irq_en_reg <= 4'h0;
      hi_run_reg <= 9'h0;
      lo_run_reg <= 9'h0;
      fresh_reg <= 1'b1;
    end else begin
      if (wr_hit && wr_idx == IDX_CTRL1) begin
        idle_lvl_reg <= wb_req_in.dat[C1_IDLE_LVL];
      end
      if (wr_hit && wr_idx == IDX_CTRL2) begin
        irq_en_reg <= wb_req_in.dat[7:4];
      end
      hi_run_reg <= tx_hi ? hi_run_reg + hi_inc : 9'h0;
      lo_run_reg <= tx_lo ? lo_run_reg + lo_inc : 9'h0;
      fresh_reg <= !tx_line_oe_out || (fresh_reg && tx_line_out);
    end
  end
  // ==========================================================
  // Properties
  default clocking dc @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);
  a_ack_one_wait: assert property (req_live |=> wb_rsp_out.ack)
    else $error("ack late");
  a_ack_pulse: assert property (wb_rsp_out.ack |=> !wb_rsp_out.ack)
    else $error("ack held");
  a_oe_pair: assert property (sync_clk_oe_out == tx_line_oe_out)
    else $error("enables differ");
  a_sclk_pulse: assert property (
    $rose(sclk_act) |-> sclk_act [*8] ##1 !sclk_act)
    else $error("clock pulse width");
  a_sclk_rest: assert property (
    tx_line_oe_out && hi_run_reg > REST_MIN |-> sync_clk_out == idle_lvl_reg)
    else $error("clock not at rest");
  a_irq_gated: assert property (
    irq_out |-> (irq_en_reg | $past(irq_en_reg) | $past(irq_en_reg, 2)) != 4'h0)
    else $error("irq without enable");
  a_preamble_ones: assert property (
    tx_lo && fresh_reg |-> hi_run_reg >= PRE_MIN)
    else $error("preamble short");
  a_break_mark: assert property (
    $rose(tx_line_out) && tx_line_oe_out && lo_run_reg >= PRE_MIN
    |-> tx_line_out [*8] ##1 tx_line_out [*8])
    else $error("no mark after break");
  c_irq: cover property ($rose(irq_out));
  c_break: cover property (lo_run_reg >= PRE_MIN);
  c_sclk: cover property ($rose(sclk_act));
endmodule : sp_serial_port_chk

bind sp_serial_port sp_serial_port_chk chk_i (
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
  .wb_req_in(wb_req_in), .wb_rsp_out(wb_rsp_out),
  .rx_line_in(rx_line_in), .tx_line_out(tx_line_out),
  .tx_line_oe_out(tx_line_oe_out), .sync_clk_out(sync_clk_out),
  .sync_clk_oe_out(sync_clk_oe_out), .irq_out(irq_out)
);

// ==== sp_remote_peer.sv ====
`timescale 1ns/1ps
module sp_remote_peer (
  input wire logic clk_in,
  input wire logic tx_in,
  input wire logic tx_oe_in,
  input wire logic sclk_in,
  input wire logic nine_in,
  output logic rx_out
);
  int got_q[$];
  int clk_q[$];
  int low_q[$];
  int low_n = 0;
  initial rx_out = 1'b1;
  // ==========================================================
  // Low runs on the transmit line
  always @(posedge clk_in) begin
    if (tx_oe_in && !tx_in) begin
      low_n <= low_n + 1;
    end else begin
      if (low_n != 0) low_q.push_back(low_n);
      low_n <= 0;
    end
  end
  // ==========================================================
  // Frame decoder, 16 clocks a bit
  // start, data LSB first, stop
  always begin : rx_frame
    int w;
    int t;
    int nb;
    logic prev;
    @(posedge clk_in);
    if (tx_oe_in && !tx_in) begin
      nb = nine_in ? 9 : 8;
      w = 0;
      t = 0;
      prev = sclk_in;
      for (int i = 0; i < 16 * nb + 24; i++) begin
        @(posedge clk_in);
        if (sclk_in != prev) t++;
        prev = sclk_in;
        if (i % 16 == 6 && i >= 16 && i < 16 * nb + 16) w |= int'(tx_in) << (i / 16 - 1);
      end
      got_q.push_back(w);
      clk_q.push_back(t / 2);
    end
  end
  // one start, data LSB first, one stop
  task automatic send(input int w, input int nb);
    for (int i = -1; i <= nb; i++) begin
      rx_out <= (i < 0) ? 1'b0 : (i == nb) ? 1'b1 : w[i];
      repeat (16) @(posedge clk_in);
    end
  endtask : send
endmodule : sp_remote_peer

// ==== sp_serial_port_tb_top.sv ====
`timescale 1ns/1ps
module sp_serial_port_tb_top;
  import sp_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  sp_wb_req_s req = '0;
  sp_wb_rsp_s rsp;
  logic rx_line, tx_line, tx_oe, sclk, sclk_oe, irq;
  logic nine = 1'b0;
  int miscompares = 0;
  int compares = 0;
  int tx_exp[$];
  logic [7:0] rd;
  always #20 clk_sys_in = ~clk_sys_in;
  sp_serial_port uut (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .wb_req_in(req),
    .wb_rsp_out(rsp), .rx_line_in(rx_line), .tx_line_out(tx_line),
    .tx_line_oe_out(tx_oe), .sync_clk_out(sclk),
    .sync_clk_oe_out(sclk_oe), .irq_out(irq)
  );
  sp_remote_peer peer (
    .clk_in(clk_sys_in), .tx_in(tx_line), .tx_oe_in(tx_oe),
    .sclk_in(sclk), .nine_in(nine), .rx_out(rx_line)
  );
  // ==========================================================
  // Reporting and bus tasks
  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  task automatic chk_reg(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask : chk_reg
  task automatic chk_word(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask : chk_word
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask : tick
  task automatic wb(input logic we, input logic [5:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    req <= '{1'b1, 1'b1, we, {idx, 2'b00}, 4'h1, {24'h0, wd}};
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (rsp.ack !== 1'b1 && n < 20);
    rd = rsp.dat[7:0];
    req <= '0;
    @(posedge clk_sys_in);
    if (n >= 20) begin
      miscompares++;
      conclude();
    end
  endtask : wb
  task automatic rdc(input logic [5:0] idx, input logic [7:0] e, input string n);
    wb(1'b0, idx, 8'h00);
    chk_reg(n, e, rd);
  endtask : rdc
  task automatic wait_q();
    int k;
    for (k = 0; k < 2000 && peer.got_q.size() == 0; k++) tick(1);
    if (peer.got_q.size() == 0) begin
      miscompares++;
      conclude();
    end
    tick(40);
  endtask : wait_q
  task automatic tx_one(input logic [7:0] d, input logic b8);
    int k;
    tx_exp.push_back(nine ? int'({b8, d}) : int'(d));
    wb(1'b1, IDX_DATA, d);
    k = 0;
    do begin
      wb(1'b0, IDX_STAT, 8'h00);
      k++;
    end while (rd[ST_TX_BUF_EMPTY_FLAG] !== 1'b1 && k < 300);
    if (k >= 300) miscompares++;
    // wait for shifter load, then disable
    wb(1'b1, IDX_CTRL2, 8'h00);
    wait_q();
    chk_word("tx word", 16'(tx_exp.pop_front()), 16'(peer.got_q.pop_front()));
  endtask : tx_one
  // ==========================================================
  // Main sequence
  initial begin : main
    logic [7:0] d;
    logic b8;
    int k;
    void'($urandom(32'h4df3));
    tick(2);
    rst_n_in <= 1'b1;
    tick(1);
    rdc(IDX_CTRL2, C2_RESET, "ctrl2");
    rdc(IDX_STAT, ST_RESET, "status");
    wb(1'b1, 6'h20, 8'hff);
    rdc(6'h20, 8'h00, "unmapped");
    d = 8'($urandom);
    wb(1'b1, IDX_CTRL1, d);
    rdc(IDX_CTRL1, d & C1_WR_MASK, "ctrl1");
    for (int m = 0; m < 4; m++) begin
      d = 8'($urandom);
      b8 = 1'($urandom);
      nine = m[1];
      // clock options set with transmitter off
      wb(1'b1, IDX_CTRL1, {1'b0, b8, 1'b0, nine, 1'b0, 2'($urandom), m[0]});
      wb(1'b1, IDX_CTRL2, 8'h08);
      tx_one(d, b8);
      chk_word("clocks", 16'(7 + m[1] + m[0]), 16'(peer.clk_q.pop_front()));
    end
    nine = 1'b0;
    wb(1'b1, IDX_CTRL1, 8'h00);
    wb(1'b1, IDX_CTRL2, 8'h08);
    tick(400);
    peer.low_q.delete();
    wb(1'b1, IDX_CTRL2, 8'h09);
    wb(1'b1, IDX_CTRL2, 8'h08);
    tick(400);
    chk_word("break len", 16'(16 * FRAME8_BITS), 16'(peer.low_q.pop_front()));
    peer.got_q.delete();
    tx_one(8'($urandom), 1'b0);
    wb(1'b1, IDX_CTRL2, 8'h00);
    tick(300);
    peer.send(int'($urandom), 8);
    tick(40);
    wb(1'b0, IDX_STAT, 8'h00);
    chk_reg("flags off", 8'h00, rd & 8'h3e);
    wb(1'b1, IDX_CTRL1, 8'h10);
    wb(1'b1, IDX_MASK, 8'h20);
    wb(1'b1, IDX_CTRL2, 8'h24);
    k = $urandom & 32'h1ff;
    peer.send(k, 9);
    tick(40);
    rdc(IDX_DATA, k[7:0], "rx byte");
    wb(1'b0, IDX_CTRL1, 8'h00);
    chk_reg("rx bit8", {7'h0, k[8]}, {7'h0, rd[C1_RXB8]});
    chk_reg("irq set", 8'h01, {7'h0, irq});
    wb(1'b1, IDX_MASK, 8'h00);
    tick(2);
    chk_reg("irq masked", 8'h00, {7'h0, irq});
    wb(1'b1, IDX_MASK, 8'h20);
    wb(1'b1, IDX_STAT, 8'h20);
    tick(2);
    chk_reg("irq cleared", 8'h00, {7'h0, irq});
    wb(1'b1, IDX_CTRL1, 8'h08);
    wb(1'b1, IDX_STAT, 8'h3e);
    wb(1'b1, IDX_CTRL2, 8'h06);
    peer.send(32'h35, 8);
    tick(40);
    wb(1'b0, IDX_STAT, 8'h00);
    chk_reg("asleep flags", 8'h00, rd & 8'h3e);
    d = 8'($urandom) | 8'h80;
    peer.send(int'(d), 8);
    tick(40);
    wb(1'b0, IDX_STAT, 8'h00);
    chk_reg("wake full", 8'h20, rd & 8'h20);
    rdc(IDX_DATA, d, "wake byte");
    wb(1'b0, IDX_CTRL2, 8'h00);
    chk_reg("awake", 8'h00, rd & 8'h02);
    wb(1'b1, IDX_CTRL1, 8'h00);
    tick(200);
    wb(1'b1, IDX_CTRL2, 8'h06);
    rdc(IDX_CTRL2, 8'h04, "sleep refused");
    conclude();
  end
endmodule : sp_serial_port_tb_top
